// ===== hdl/vip_top.sv
// interrupt prioritiser and vector generator for the core
//
// Summary of operation
// - non-maskable request always wins, ignores disable
// - unmasked and non-maskable requests release standby
// - watchdog routes non-maskable or default slot 0
// - each maskable source has mask and group flag
// - high group nests over low-group service
// - same group picks lowest default number first
// - break instruction vectors to 003EH unconditionally
// - seven external, fifteen internal maskable sources
// - pin edges priorities 1-6, vectors 0006H-0010H
// - key port falling edge priority 7, 0012H
// - async serial priorities 8-10, 0014H-0018H
// - sync serial priorities 11-12, 001AH-001CH
// - watch interval 13/001EH, overflow 21/002EH
// - timer16 events priorities 14-15, 0020H-0022H
// - aux timer match priority 16, 0024H
// - timer8 matches priorities 17-19, 0026H-002AH
// - conversion done priority 20, 002CH
// - acknowledge clears the request flag
// - reset sets every mask flag
`timescale 1ns/1ps
`include "vip_regs.svh"

module vip_top #(
    parameter int NUM_SRC = `VIP_NUM_MASKABLE
) (
    // clock and reset
    input  wire logic        CLK_SYS_I,
    input  wire logic        RESETN_I,
    // watchdog
    input  wire logic        WATCHDOG_IRQ_I,
    input  wire logic        WDT_MODE_NMI_I,
    // external sources
    input  wire logic [5:0]  EXT_PIN_IRQ_I,
    input  wire logic [7:0]  KEY_RETURN_PORT_I,
    // internal sources
    input  wire logic        ASYNC_RX_ERROR_IRQ_I,
    input  wire logic        ASYNC_RX_DONE_IRQ_I,
    input  wire logic        ASYNC_TX_DONE_IRQ_I,
    input  wire logic        SYNC_SERIAL_A_IRQ_I,
    input  wire logic        SYNC_SERIAL_B_IRQ_I,
    input  wire logic        WATCH_INTERVAL_IRQ_I,
    input  wire logic        TIMER16_EVENT0_IRQ_I,
    input  wire logic        TIMER16_EVENT1_IRQ_I,
    input  wire logic        AUX_TIMER_MATCH_IRQ_I,
    input  wire logic        TIMER8_A_MATCH_IRQ_I,
    input  wire logic        TIMER8_B_MATCH_IRQ_I,
    input  wire logic        TIMER8_C_MATCH_IRQ_I,
    input  wire logic        ADC_DONE_IRQ_I,
    input  wire logic        WATCH_OVERFLOW_IRQ_I,
    // flag access
    input  wire logic        MASK_WR_I,
    input  wire logic [21:0] MASK_DATA_I,
    input  wire logic        PRIO_WR_I,
    input  wire logic [21:0] PRIO_DATA_I,
    input  wire logic [21:0] REQ_SET_I,
    input  wire logic [21:0] REQ_CLR_I,
    output logic      [21:0] MASK_FLAGS_O,
    output logic      [21:0] PRIO_FLAGS_O,
    output logic      [21:0] REQ_FLAGS_O,
    // core side
    input  wire logic        INT_ENABLE_I,
    input  wire logic        BREAK_INSTRUCTION_I,
    input  wire logic        INT_ACK_I,
    input  wire logic        INT_RETURN_I,
    output logic             INT_REQ_O,
    output logic      [15:0] VECTOR_O,
    output logic      [2:0]  IN_SERVICE_O,
    output logic             STANDBY_RELEASE_O
);

    // elaboration-time width check
    if (NUM_SRC != `VIP_NUM_MASKABLE) begin : g_chk
        $error("vip_top: NUM_SRC must be 22");
    end

    // lowest set index with valid bit on top
    function automatic logic [5:0] vip_first(input logic [21:0] v);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 21; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, 5'(i)};
            end
        end
        return r;
    endfunction : vip_first

    vip_pkg::vip_state_t s_reg;
    vip_pkg::vip_state_t s_next;
    logic                rst_meta_reg;
    logic                rst_n;
    logic [21:0]         evt;
    logic [21:0]         cand;
    logic [5:0]          hi_sel;
    logic [5:0]          lo_sel;
    logic                key_fall;
    logic                ack;

    // reset release through two flops
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // event vector, bit index is default priority
    assign key_fall = |(s_reg.key_prev & ~KEY_RETURN_PORT_I);
    assign evt = {WATCH_OVERFLOW_IRQ_I,
                  ADC_DONE_IRQ_I,
                  TIMER8_C_MATCH_IRQ_I,
                  TIMER8_B_MATCH_IRQ_I,
                  TIMER8_A_MATCH_IRQ_I,
                  AUX_TIMER_MATCH_IRQ_I,
                  TIMER16_EVENT1_IRQ_I,
                  TIMER16_EVENT0_IRQ_I,
                  WATCH_INTERVAL_IRQ_I,
                  SYNC_SERIAL_B_IRQ_I,
                  SYNC_SERIAL_A_IRQ_I,
                  ASYNC_TX_DONE_IRQ_I,
                  ASYNC_RX_DONE_IRQ_I,
                  ASYNC_RX_ERROR_IRQ_I,
                  key_fall,
                  EXT_PIN_IRQ_I,
                  WATCHDOG_IRQ_I & ~WDT_MODE_NMI_I};

    // candidates split into the two groups
    assign cand   = s_reg.req & ~s_reg.mask;
    assign hi_sel = vip_first(cand & ~s_reg.prio);
    assign lo_sel = vip_first(cand & s_reg.prio);
    assign ack    = INT_ACK_I & s_reg.int_req;

    // next state
    always_comb begin
        logic [21:0] ack_clr;
        logic        sel_ok;
        ack_clr = 22'h000000;
        sel_ok = 1'b0;
        s_next = s_reg;
        s_next.key_prev = KEY_RETURN_PORT_I;
        if (MASK_WR_I) begin
            s_next.mask = MASK_DATA_I;
        end
        if (PRIO_WR_I) begin
            s_next.prio = PRIO_DATA_I;
        end
        // return pops the innermost service level
        if (INT_RETURN_I) begin
            if (s_reg.svc_nmi) begin
                s_next.svc_nmi = 1'b0;
            end else if (s_reg.svc_hi) begin
                s_next.svc_hi = 1'b0;
            end else begin
                s_next.svc_lo = 1'b0;
            end
        end
        // acknowledge clears the flag and marks service, except for break
        if (ack) begin
            case (s_reg.kind)
                vip_pkg::KIND_NMI: begin
                    s_next.nmi_pend = 1'b0;
                    s_next.svc_nmi  = 1'b1;
                end
                vip_pkg::KIND_BRK: begin
                    s_next.brk_pend = 1'b0;
                end
                vip_pkg::KIND_HI: begin
                    ack_clr[s_reg.idx] = 1'b1;
                    s_next.svc_hi = 1'b1;
                end
                default: begin
                    ack_clr[s_reg.idx] = 1'b1;
                    s_next.svc_lo = 1'b1;
                end
            endcase
        end
        // sets win over clears
        s_next.req = (s_reg.req & ~REQ_CLR_I & ~ack_clr) | REQ_SET_I | evt;
        if (WATCHDOG_IRQ_I && WDT_MODE_NMI_I) begin
            s_next.nmi_pend = 1'b1;
        end
        if (BREAK_INSTRUCTION_I) begin
            s_next.brk_pend = 1'b1;
        end
        // pick what to present to the core
        if (s_reg.nmi_pend && !s_reg.svc_nmi) begin
            sel_ok = 1'b1;
            s_next.kind = vip_pkg::KIND_NMI;
            s_next.idx  = 5'h00;
            s_next.vec  = `VIP_VEC_NMI;
        end else if (s_reg.brk_pend) begin
            sel_ok = 1'b1;
            s_next.kind = vip_pkg::KIND_BRK;
            s_next.idx  = 5'h00;
            s_next.vec  = `VIP_VEC_BRK;
        end else if (INT_ENABLE_I && !s_reg.svc_nmi && !s_reg.svc_hi
                     && hi_sel[5]) begin
            sel_ok = 1'b1;
            s_next.kind = vip_pkg::KIND_HI;
            s_next.idx  = hi_sel[4:0];
            s_next.vec  = `VIP_VEC_BASE + {10'h000, hi_sel[4:0], 1'b0};
        end else if (INT_ENABLE_I && !s_reg.svc_nmi && !s_reg.svc_hi
                     && !s_reg.svc_lo && lo_sel[5]) begin
            sel_ok = 1'b1;
            s_next.kind = vip_pkg::KIND_LO;
            s_next.idx  = lo_sel[4:0];
            s_next.vec  = `VIP_VEC_BASE + {10'h000, lo_sel[4:0], 1'b0};
        end
        s_next.int_req = sel_ok & ~ack;
        s_next.standby = (|cand) | s_reg.nmi_pend;
    end

    // state register
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            s_reg          <= '0;
            s_reg.mask     <= `VIP_MASK_RST;
            s_reg.prio     <= `VIP_PRIO_RST;
            s_reg.key_prev <= `VIP_KEY_RST;
            s_reg.kind     <= vip_pkg::KIND_NMI;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs
    assign INT_REQ_O         = s_reg.int_req;
    assign VECTOR_O          = s_reg.vec;
    assign IN_SERVICE_O      = {s_reg.svc_nmi, s_reg.svc_hi, s_reg.svc_lo};
    assign STANDBY_RELEASE_O = s_reg.standby;
    assign MASK_FLAGS_O      = s_reg.mask;
    assign PRIO_FLAGS_O      = s_reg.prio;
    assign REQ_FLAGS_O       = s_reg.req;

    // checks
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!rst_n);

    sequence nmi_waiting_s;
        s_reg.nmi_pend && !s_reg.svc_nmi && !ack;
    endsequence
    sequence ack_s;
        ack && s_reg.kind inside {vip_pkg::KIND_HI, vip_pkg::KIND_LO};
    endsequence

    nmi_wins_a: assert property (nmi_waiting_s |=> s_reg.int_req
        && s_reg.kind == vip_pkg::KIND_NMI && s_reg.vec == `VIP_VEC_NMI)
        else $error("pending nmi not presented");
    standby_rel_a: assert property ((|cand) |=> STANDBY_RELEASE_O)
        else $error("standby release missing");
    wdt_nmi_a: assert property (WATCHDOG_IRQ_I && WDT_MODE_NMI_I
        |=> s_reg.nmi_pend && !s_reg.req[`VIP_WDT_IDX] || $past(ack))
        else $error("watchdog not routed as nmi");
    wdt_mask_a: assert property (WATCHDOG_IRQ_I && !WDT_MODE_NMI_I
        |=> s_reg.req[`VIP_WDT_IDX])
        else $error("watchdog not routed as maskable");
    lo_block_a: assert property (s_reg.svc_lo && !s_reg.svc_hi
        && s_reg.int_req |-> s_reg.kind != vip_pkg::KIND_LO)
        else $error("low group nested on low group");
    hi_nest_a: assert property (s_reg.int_req
        && s_reg.kind == vip_pkg::KIND_HI |-> !s_reg.svc_hi)
        else $error("high group nested on high group");
    brk_vec_a: assert property (BREAK_INSTRUCTION_I && !s_reg.nmi_pend
        && !ack |=> ##1 s_reg.int_req && VECTOR_O == `VIP_VEC_BRK)
        else $error("break vector not presented");
    vec_map_a: assert property (s_reg.int_req
        && s_reg.kind inside {vip_pkg::KIND_HI, vip_pkg::KIND_LO}
        |-> VECTOR_O == `VIP_VEC_BASE + {10'h000, s_reg.idx, 1'b0})
        else $error("vector does not match source");
    ack_clear_a: assert property (ack_s ##0
        (!REQ_SET_I[s_reg.idx] && !evt[s_reg.idx])
        |=> !s_reg.req[$past(s_reg.idx)])
        else $error("request flag kept after acknowledge");
    ack_drop_a: assert property (ack |=> !INT_REQ_O)
        else $error("request held after acknowledge");
    mask_rst_a: assert property (!$past(rst_n) |->
        s_reg.mask == `VIP_MASK_RST)
        else $error("mask flags not set by reset");

    // key edge, enable gating and service bookkeeping
    key_edge_a: assert property (key_fall
        |=> s_reg.req[`VIP_KEY_IDX])
        else $error("key edge not flagged");
    ie_gate_a: assert property (!INT_ENABLE_I
        |=> !(s_reg.int_req
        && s_reg.kind inside {vip_pkg::KIND_HI, vip_pkg::KIND_LO}))
        else $error("maskable presented while disabled");
    brk_keep_a: assert property (ack
        && s_reg.kind == vip_pkg::KIND_BRK && !INT_RETURN_I
        |=> IN_SERVICE_O == $past(IN_SERVICE_O))
        else $error("break changed service state");
    hi_svc_a: assert property (ack
        && s_reg.kind == vip_pkg::KIND_HI |=> s_reg.svc_hi)
        else $error("high group service not marked");
    nmi_svc_a: assert property (s_reg.svc_nmi
        && s_reg.int_req |-> s_reg.kind == vip_pkg::KIND_BRK)
        else $error("request presented over nmi service");

endmodule : vip_top

// ===== shared/vip_pkg.sv
// types of the vectored interrupt priority unit
package vip_pkg;
    typedef enum logic [1:0] {
        KIND_NMI,
        KIND_BRK,
        KIND_HI,
        KIND_LO
    } vip_kind_t;

    typedef struct packed {
        logic [21:0] mask;
        logic [21:0] prio;
        logic [21:0] req;
        logic        nmi_pend;
        logic        brk_pend;
        logic        svc_nmi;
        logic        svc_hi;
        logic        svc_lo;
        logic [7:0]  key_prev;
        logic        int_req;
        logic [15:0] vec;
        vip_kind_t   kind;
        logic [4:0]  idx;
        logic        standby;
    } vip_state_t;
endpackage : vip_pkg

// ===== shared/vip_regs.svh
// constants of the vectored interrupt priority unit
`ifndef VIP_REGS_SVH
`define VIP_REGS_SVH
`define VIP_NUM_MASKABLE 22
`define VIP_KEY_W        8
`define VIP_VEC_NMI      16'h0004
`define VIP_VEC_BASE     16'h0004
`define VIP_VEC_BRK      16'h003E
`define VIP_MASK_RST     22'h3FFFFF
`define VIP_PRIO_RST     22'h3FFFFF
`define VIP_KEY_RST      8'hFF
`define VIP_WDT_IDX      0
`define VIP_KEY_IDX      7
`endif

// ===== tb/testbench.sv
// self-checking bench of the interrupt prioritiser
`timescale 1ns/1ps
module testbench;
    logic        clk = 1'b0, rstn = 1'b0, wd_nmi = 1'b0, ie = 1'b0;
    logic        break_req = 1'b0, ret = 1'b0, ack_en = 1'b0;
    logic        mask_wr = 1'b0, prio_wr = 1'b0, int_req, standby, ack;
    logic [21:0] src = '0, mask_d = '0, prio_d = '0, req_set = '0;
    logic [21:0] req_clr = '0;
    logic [21:0] mask_f, prio_f, req_f;
    logic [7:0]  key = 8'hFF, acks;
    logic [2:0]  delay = 3'h0, in_svc;
    logic [15:0] vec, vec_seen;
    int          bad_count = 0, checks = 0;

    vip_top vip_top_i (
        .CLK_SYS_I(clk), .RESETN_I(rstn), .WATCHDOG_IRQ_I(src[0]),
        .WDT_MODE_NMI_I(wd_nmi), .EXT_PIN_IRQ_I(src[6:1]),
        .KEY_RETURN_PORT_I(key), .ASYNC_RX_ERROR_IRQ_I(src[8]),
        .ASYNC_RX_DONE_IRQ_I(src[9]), .ASYNC_TX_DONE_IRQ_I(src[10]),
        .SYNC_SERIAL_A_IRQ_I(src[11]), .SYNC_SERIAL_B_IRQ_I(src[12]),
        .WATCH_INTERVAL_IRQ_I(src[13]), .TIMER16_EVENT0_IRQ_I(src[14]),
        .TIMER16_EVENT1_IRQ_I(src[15]), .AUX_TIMER_MATCH_IRQ_I(src[16]),
        .TIMER8_A_MATCH_IRQ_I(src[17]), .TIMER8_B_MATCH_IRQ_I(src[18]),
        .TIMER8_C_MATCH_IRQ_I(src[19]), .ADC_DONE_IRQ_I(src[20]),
        .WATCH_OVERFLOW_IRQ_I(src[21]), .MASK_WR_I(mask_wr),
        .MASK_DATA_I(mask_d), .PRIO_WR_I(prio_wr), .PRIO_DATA_I(prio_d),
        .REQ_SET_I(req_set), .REQ_CLR_I(req_clr),
        .MASK_FLAGS_O(mask_f), .PRIO_FLAGS_O(prio_f), .REQ_FLAGS_O(req_f),
        .INT_ENABLE_I(ie), .BREAK_INSTRUCTION_I(break_req),
        .INT_ACK_I(ack), .INT_RETURN_I(ret), .INT_REQ_O(int_req),
        .VECTOR_O(vec), .IN_SERVICE_O(in_svc), .STANDBY_RELEASE_O(standby)
    );

    vip_core_model vip_core_model_i (
        .clk_i(clk), .rst_n_i(rstn), .int_req_i(int_req), .vec_i(vec),
        .ack_en_i(ack_en), .delay_i(delay), .int_ack_o(ack),
        .vec_seen_o(vec_seen), .acks_o(acks)
    );

    // clock generator
    initial begin
        forever #5 clk = ~clk;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input string name, input logic [21:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    // one source event; slot 7 comes from a key falling edge
    task automatic fire(input int k);
        if (k == 7) @(posedge clk) key <= 8'hF7;
        else @(posedge clk) src[k] <= 1'b1;
        @(posedge clk) begin
            src <= '0;
            key <= 8'hFF;
        end
    endtask : fire

    // wait for the core to take a request, compare its vector
    task automatic take(input logic [15:0] exp);
        logic [7:0] a0;
        int         i;
        a0 = acks;
        for (i = 0; i < 40 && acks === a0; i++) @(posedge clk);
        #1;
        if (i == 40) begin
            bad_count++;
            end_of_test;
        end else begin
            check("vector", {6'h00, vec_seen}, {6'h00, exp});
        end
    endtask : take

    task automatic ret_pulse;
        @(posedge clk) ret <= 1'b1;
        @(posedge clk) ret <= 1'b0;
    endtask : ret_pulse

    task automatic flags(input logic [21:0] m, p);
        @(posedge clk) begin
            mask_wr <= 1'b1;
            prio_wr <= 1'b1;
            mask_d  <= m;
            prio_d  <= p;
        end
        @(posedge clk) begin
            mask_wr <= 1'b0;
            prio_wr <= 1'b0;
        end
    endtask : flags

    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        step(3);
        check("mask", mask_f, 22'h3FFFFF);
        check("prio", prio_f, 22'h3FFFFF);
        check("req", req_f, 22'h000000);
        // set and clear strobes together, then clear alone, while masked
        @(posedge clk) begin
            req_set <= 22'h000002;
            req_clr <= 22'h000002;
        end
        step(1);
        check("set_wins", req_f, 22'h000002);
        check("standby", {21'h0, standby}, 22'h0);
        @(posedge clk) req_set <= '0;
        step(1);
        check("soft_clr", req_f, 22'h000000);
        @(posedge clk) req_clr <= '0;
        flags(22'h000000, 22'h000000);
        @(posedge clk) begin
            ie     <= 1'b1;
            ack_en <= 1'b1;
        end
        // every maskable source alone, vector and flag clear on ack
        for (int k = 0; k < 22; k++) begin
            fire(k);
            take(16'h0004 + 16'(2 * k));
            check("cleared", {21'h0, req_f[k]}, 22'h0);
            ret_pulse;
        end
        // same group order, then high group nests over low service
        @(posedge clk) begin
            ie      <= 1'b0;
            req_set <= 22'h204008;
        end
        @(posedge clk) req_set <= '0;
        flags(22'h000000, 22'h3FFFFF);
        @(posedge clk) ie <= 1'b1;
        take(16'h000A);
        flags(22'h000000, 22'h3FBFFF);
        take(16'h0020);
        check("service", {19'h0, in_svc}, 22'h000003);
        ret_pulse;
        ret_pulse;
        take(16'h002E);
        ret_pulse;
        // masked source is held, released by unmasking, slow core
        flags(22'h3FFFFF, 22'h3FFFFF);
        @(posedge clk) delay <= 3'h3;
        fire(5);
        step(3);
        check("flags", req_f, 22'h000020);
        check("standby", {21'h0, standby}, 22'h0);
        flags(22'h3FFFDF, 22'h3FFFFF);
        step(1);
        check("standby", {21'h0, standby}, 22'h1);
        take(16'h000E);
        ret_pulse;
        // watchdog as non-maskable while disabled
        @(posedge clk) begin
            ie     <= 1'b0;
            wd_nmi <= 1'b1;
            ack_en <= 1'b0;
            delay  <= 3'h0;
        end
        fire(0);
        step(2);
        check("nmi_req", {21'h0, int_req}, 22'h1);
        check("standby", {21'h0, standby}, 22'h1);
        check("flags", req_f, 22'h000000);
        @(posedge clk) ack_en <= 1'b1;
        take(16'h0004);
        ret_pulse;
        // break instruction while disabled, no return for it
        @(posedge clk) break_req <= 1'b1;
        @(posedge clk) break_req <= 1'b0;
        take(16'h003E);
        end_of_test;
    end
endmodule : testbench

// ===== tb/vip_core_model.sv
// core model: acknowledges presented requests and keeps the vector seen
`timescale 1ns/1ps
module vip_core_model (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // from the prioritiser
    input  wire logic        int_req_i,
    input  wire logic [15:0] vec_i,
    // behaviour control
    input  wire logic        ack_en_i,
    input  wire logic [2:0]  delay_i,
    // to the prioritiser and the bench
    output logic             int_ack_o,
    output logic      [15:0] vec_seen_o,
    output logic      [7:0]  acks_o
);
    logic [2:0] cnt_reg;

    // ack after delay_i cycles, vector fetched at the taken edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_ack_o  <= 1'b0;
            cnt_reg    <= 3'h0;
            vec_seen_o <= 16'h0000;
            acks_o     <= 8'h00;
        end else begin
            int_ack_o <= 1'b0;
            if (int_ack_o && int_req_i) begin
                vec_seen_o <= vec_i;
                acks_o     <= acks_o + 8'h01;
                cnt_reg    <= 3'h0;
            end else if (int_req_i && ack_en_i && !int_ack_o) begin
                if (cnt_reg >= delay_i) int_ack_o <= 1'b1;
                else cnt_reg <= cnt_reg + 3'h1;
            end
        end
    end
endmodule : vip_core_model
